// [design/fault_flag_and_irq_mask_bank.sv]
// fault flags, interrupt masks and interrupt pin for the charger fault bank
//
// Function
// [R1] mask bit 0 lets its event interrupt; mask bit 1 suppresses it
// [R2] a masked event still sets its flag but gives no interrupt
// [R3] every mask bit is read/write and resets to 0
// [R4] first mask: input ov, input pulldown, bus pulldown, drop ov, bus ov/oc, ucp
// [R5] second mask: batt ov, batt oc, vreg, ireg, overtemp, low, high, conv oc
// [R6] second flag register uses the same bit order as second mask
// [R7] second flag register is read-to-clear and resets to all zeros
// [R8] battery overvolt flag sets on fault; read clears only after fault gone
// [R9] battery overcurrent flag sets on fault; any read clears it
// [R10] regulation flags set on regulation; read clears once regulation ended
// [R11] die overtemp flag sets on fault; read clears only after it is gone
// [R12] bus-low flag: ratio below twice low limit divider, limit in bypass
// [R13] bus-high flag: ratio above twice high limit divider, limit in bypass
// [R14] converter overcurrent: charge then discharge fet ocp in divider mode
// [R15] first mask register sits at offset 0x0C and resets to zeros
// [R16] interrupt pin pulses low when a flag newly sets with mask 0
`timescale 1ns/100ps
`include "fault_irq_regs.svh"
module fault_flag_and_irq_mask_bank
  import fault_irq_pkg::*;
#(
  parameter int IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_divider_mode,
  input wire logic [7:0] i_first_group_flag_new,
  input wire logic i_battery_overvolt,
  input wire logic i_battery_overcurrent,
  input wire logic i_volt_regulation,
  input wire logic i_current_regulation,
  input wire logic i_die_overtemp,
  input wire logic i_ratio_below_low,
  input wire logic i_ratio_below_twice_low,
  input wire logic i_ratio_above_high,
  input wire logic i_ratio_above_twice_high,
  input wire logic i_charge_switch_fet_ocp,
  input wire logic i_discharge_switch_fet_ocp,
  output logic [7:0] o_fault_irq_mask_first,
  output logic o_irq_out_low
);

  // ==========================================
  // detector inputs, synchronised
  logic [10:0] det_async;
  logic [10:0] det;
  logic [10:0] det_prev;
  logic [10:0] next_det_prev;

  assign det_async = {i_battery_overvolt, i_battery_overcurrent,
                      i_volt_regulation, i_current_regulation,
                      i_die_overtemp, i_ratio_below_low,
                      i_ratio_below_twice_low, i_ratio_above_high,
                      i_ratio_above_twice_high, i_charge_switch_fet_ocp,
                      i_discharge_switch_fet_ocp};

  pin_filter #(
    .WIDTH(11)
  ) u_pin_filter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(det_async),
    .o_level(det)
  );

  // rising edge of a filtered detector level
  function automatic logic rose(input logic now, input logic prev);
    rose = now & ~prev;
  endfunction : rose

  // ==========================================
  // state
  reg_byte_t fault_irq_mask_first;
  reg_byte_t fault_irq_mask_second;
  reg_byte_t fault_flags_second;
  reg_byte_t read_data;
  logic charge_ocp_seen;
  irq_state_t irq_state;
  logic [15:0] irq_count;

  reg_byte_t next_fault_irq_mask_first;
  reg_byte_t next_fault_irq_mask_second;
  reg_byte_t next_fault_flags_second;
  reg_byte_t next_read_data;
  logic next_charge_ocp_seen;
  irq_state_t next_irq_state;
  logic [15:0] next_irq_count;

  // ==========================================
  // fault conditions and set events
  reg_byte_t cond;
  reg_byte_t set_vec;
  reg_byte_t clear_ok;
  reg_byte_t new_second;
  reg_byte_t new_first;
  logic conv_event;
  logic read_flags;
  logic irq_trigger;

  // the ratio comparators give both thresholds; mode picks which counts
  always_comb begin
    cond = '0;
    cond[`BIT_BATTERY_OVERVOLT] = det[10]; // R8
    cond[`BIT_BATTERY_OVERCURRENT] = det[9];
    cond[`BIT_VOLT_REGULATION] = det[8]; // R10
    cond[`BIT_CURRENT_REGULATION] = det[7]; // R10
    cond[`BIT_DIE_OVERTEMP] = det[6]; // R11
    cond[`BIT_BUS_LOW] = i_divider_mode ? det[4] : det[5]; // R12
    cond[`BIT_BUS_HIGH] = i_divider_mode ? det[2] : det[3]; // R13
    cond[`BIT_CONVERTER_OVERCURRENT] = 1'b0;
  end

  // converter ocp needs a charge fet trip followed by a discharge fet trip
  always_comb begin
    conv_event = i_divider_mode & charge_ocp_seen
                 & rose(det[0], det_prev[0]); // R14
    next_charge_ocp_seen = charge_ocp_seen;
    if (!i_divider_mode || conv_event) begin
      next_charge_ocp_seen = 1'b0;
    end else if (rose(det[1], det_prev[1])) begin
      next_charge_ocp_seen = 1'b1; // R14
    end
    next_det_prev = det;
  end

  // level bits hold while the fault lasts; edge bits clear on any read
  always_comb begin
    read_flags = i_reg_rd && (i_reg_addr == `OFS_FAULT_FLAGS_SECOND);
    set_vec = cond;
    set_vec[`BIT_BATTERY_OVERCURRENT] =
      rose(det[9], det_prev[9]); // R9
    set_vec[`BIT_CONVERTER_OVERCURRENT] = conv_event; // R14
    clear_ok = ~cond; // R8 R10 R11 R12 R13
    clear_ok[`BIT_BATTERY_OVERCURRENT] = 1'b1; // R9
    clear_ok[`BIT_CONVERTER_OVERCURRENT] = 1'b1; // R14
    // a set in the same cycle as the read wins over the clear
    next_fault_flags_second = set_vec |
      (fault_flags_second & ~(read_flags ? clear_ok : 8'h00)); // R7 R6
  end

  // ==========================================
  // register port: mask writes and read data capture
  always_comb begin
    next_fault_irq_mask_first = fault_irq_mask_first;
    next_fault_irq_mask_second = fault_irq_mask_second;
    next_read_data = read_data;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `OFS_FAULT_IRQ_MASK_FIRST: begin
          next_fault_irq_mask_first = i_reg_wdata; // R3 R4 R15
        end
        `OFS_FAULT_IRQ_MASK_SECOND: begin
          next_fault_irq_mask_second = i_reg_wdata; // R3 R5
        end
        default: begin
          // flag register and unmapped offsets ignore writes
        end
      endcase
    end
    // the value read is the one before the read clears it
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_FAULT_IRQ_MASK_FIRST: next_read_data = fault_irq_mask_first;
        `OFS_FAULT_FLAGS_SECOND: next_read_data = fault_flags_second;
        `OFS_FAULT_IRQ_MASK_SECOND: next_read_data = fault_irq_mask_second;
        default: next_read_data = `RST_READ_DATA;
      endcase
    end
  end

  // ==========================================
  // interrupt request: newly set flags whose mask bit is 0
  always_comb begin
    new_second = next_fault_flags_second & ~fault_flags_second
                 & ~fault_irq_mask_second; // R1 R2 R16
    new_first = i_first_group_flag_new & ~fault_irq_mask_first; // R1 R2
    irq_trigger = (|new_second) | (|new_first); // R16
  end

  // a fresh event during a pulse restarts it, so none is merged silently
  always_comb begin
    next_irq_state = irq_state;
    next_irq_count = irq_count;
    case (irq_state)
      IRQ_IDLE: begin
        if (irq_trigger) begin
          next_irq_state = IRQ_LOW;
          next_irq_count = 16'(IRQ_PULSE_CYCLES - 1);
        end
      end
      IRQ_LOW: begin
        if (irq_trigger) begin
          next_irq_count = 16'(IRQ_PULSE_CYCLES - 1);
        end else if (irq_count == 16'h0000) begin
          next_irq_state = IRQ_IDLE;
        end else begin
          next_irq_count = irq_count - 16'h0001;
        end
      end
      default: begin
        next_irq_state = IRQ_IDLE;
        next_irq_count = 16'h0000;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fault_irq_mask_first <= `RST_FAULT_IRQ_MASK_FIRST; // R3 R15
      fault_irq_mask_second <= `RST_FAULT_IRQ_MASK_SECOND; // R3
      fault_flags_second <= `RST_FAULT_FLAGS_SECOND; // R7
      read_data <= `RST_READ_DATA;
      charge_ocp_seen <= 1'b0;
      det_prev <= '0;
      irq_state <= IRQ_IDLE;
      irq_count <= 16'h0000;
    end else begin
      fault_irq_mask_first <= next_fault_irq_mask_first;
      fault_irq_mask_second <= next_fault_irq_mask_second;
      fault_flags_second <= next_fault_flags_second;
      read_data <= next_read_data;
      charge_ocp_seen <= next_charge_ocp_seen;
      det_prev <= next_det_prev;
      irq_state <= next_irq_state;
      irq_count <= next_irq_count;
    end
  end

  assign o_reg_rdata = read_data;
  assign o_fault_irq_mask_first = fault_irq_mask_first;
  assign o_irq_out_low = (irq_state != IRQ_LOW); // R16

endmodule : fault_flag_and_irq_mask_bank

// [design/fault_irq_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FAULT_IRQ_REGS_SVH
`define FAULT_IRQ_REGS_SVH

// ==========================================
// register offsets
`define OFS_FAULT_IRQ_MASK_FIRST 8'h0C
`define OFS_FAULT_FLAGS_SECOND 8'h0D
`define OFS_FAULT_IRQ_MASK_SECOND 8'h0E

// ==========================================
// reset values
`define RST_FAULT_IRQ_MASK_FIRST 8'h00
`define RST_FAULT_FLAGS_SECOND 8'h00
`define RST_FAULT_IRQ_MASK_SECOND 8'h00
`define RST_READ_DATA 8'h00

// ==========================================
// bit positions, first mask register
`define BIT_INPUT_OVERVOLT 7
`define BIT_INPUT_PULLDOWN 6
`define BIT_BUS_PULLDOWN 5
`define BIT_DROP_OVERVOLT 4
`define BIT_BUS_OVERVOLT 3
`define BIT_BUS_OVERCURRENT 2
`define BIT_UNDERCURRENT_RISE 1
`define BIT_UNDERCURRENT_FALL 0

// ==========================================
// bit positions, second flag and mask registers
`define BIT_BATTERY_OVERVOLT 7
`define BIT_BATTERY_OVERCURRENT 6
`define BIT_VOLT_REGULATION 5
`define BIT_CURRENT_REGULATION 4
`define BIT_DIE_OVERTEMP 3
`define BIT_BUS_LOW 2
`define BIT_BUS_HIGH 1
`define BIT_CONVERTER_OVERCURRENT 0

// ==========================================
// interrupt pulse length on the pin, in clock cycles
`define IRQ_PULSE_CYCLES 64

`endif

// [design/fault_irq_pkg.sv]
// types shared by the fault flag and interrupt mask bank
package fault_irq_pkg;

  // ==========================================
  // interrupt pin sequencer states, gray coded
  typedef enum logic {
    IRQ_IDLE = 1'b0,
    IRQ_LOW = 1'b1
  } irq_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage : fault_irq_pkg

// [design/pin_filter.sv]
// three-stage synchroniser with agreement filter for detector inputs
`timescale 1ns/100ps
module pin_filter #(
  parameter int WIDTH = 11
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // ==========================================
  // a bit only moves once stages two and three agree, so a metastable
  // settle in stage one cannot reach the flags
  always_comb begin
    next_level = (stage2 & stage3) | (level & (stage2 | stage3));
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign o_level = level;

endmodule : pin_filter

// [testbench/fault_bank_monitor.sv]
// port checker for the fault flag bank
`timescale 1ns/100ps
module fault_bank_monitor #(
  parameter int IRQ_PULSE_CYCLES = 64
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_first_group_flag_new,
  input wire logic i_battery_overvolt,
  input wire logic i_battery_overcurrent,
  input wire logic [7:0] o_fault_irq_mask_first,
  input wire logic o_irq_out_low
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] shadow2;
  logic [7:0] low_cnt;
  logic [3:0] ov_run;
  logic [3:0] oc_low;
  logic rd_flags;
  assign rd_flags = i_reg_rd && i_reg_addr == 8'h0D;
  // second mask shadow, pin low length, detector run lengths (saturating)
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      shadow2 <= 8'h00;
      low_cnt <= 8'h00;
      ov_run <= 4'h0;
      oc_low <= 4'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'h0E) begin
        shadow2 <= i_reg_wdata;
      end
      low_cnt <= o_irq_out_low ? 8'h00 : low_cnt + 8'h01;
      ov_run <= i_battery_overvolt ? ov_run + 4'(ov_run != 4'hF) : 4'h0;
      oc_low <= i_battery_overcurrent ? 4'h0 : oc_low + 4'(oc_low != 4'hF);
    end
  end
  // ==========
  // register port
  mask_first_wr_a: assert property (
    i_reg_wr && i_reg_addr == 8'h0C |=>
    o_fault_irq_mask_first == $past(i_reg_wdata)) else $error("mask1 wr");
  mask_first_rd_a: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == 8'h0C |=>
    o_reg_rdata == $past(o_fault_irq_mask_first)) else $error("mask1 rd");
  mask_second_rd_a: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == 8'h0E |=>
    o_reg_rdata == $past(shadow2)) else $error("mask2 rd");
  rdata_hold_a: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
  ovp_keep_a: assert property (
    ov_run >= 4'h8 && rd_flags |=> o_reg_rdata[7]) else $error("ovp lost");
  ocp_clear_a: assert property (
    oc_low >= 4'h8 && rd_flags ##2 rd_flags |=> !o_reg_rdata[6])
    else $error("ocp kept");
  // ==========
  // interrupt pin
  irq_first_a: assert property (
    |(i_first_group_flag_new & ~o_fault_irq_mask_first) |=> !o_irq_out_low)
    else $error("no pulse");
  irq_len_a: assert property (
    $rose(o_irq_out_low) |-> low_cnt >= IRQ_PULSE_CYCLES)
    else $error("pulse short");
endmodule : fault_bank_monitor

bind fault_flag_and_irq_mask_bank fault_bank_monitor #(
  .IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)
) mon (
  .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_first_group_flag_new(i_first_group_flag_new),
  .i_battery_overvolt(i_battery_overvolt),
  .i_battery_overcurrent(i_battery_overcurrent),
  .o_fault_irq_mask_first(o_fault_irq_mask_first),
  .o_irq_out_low(o_irq_out_low)
);

// [testbench/host_model.sv]
// host side model: byte register port master
`timescale 1ns/100ps
module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // one strobe cycle; idle address and data are inverted so stale values
  // can never pass for a real request
  task automatic access(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1 q = i_rdata;
  endtask : access
endmodule : host_model

// [testbench/test_fault_flag_and_irq_mask_bank.sv]
// self-checking bench for the fault flag and interrupt mask bank
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module test_fault_flag_and_irq_mask_bank;
  import fault_irq_pkg::*;
  localparam int PULSE = 4;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_divider_mode = 1'b1;
  logic [7:0] i_first_group_flag_new = 8'h00;
  logic [10:0] det = 11'h000;
  logic [7:0] addr, wdata, rdata, mask_out;
  logic wr, rd, irq_n;
  logic saw_low = 1'b0;
  reg_byte_t q;
  int n_errors = 0;
  int samples_checked = 0;
  int m1, m2, b;
  int src [8] = '{10, 8, 6, 4, 3, 2, 1, 0};
  logic [7:0] lvl = 8'hBE;
  always #2 i_clk = ~i_clk;
  // pin watcher, looks at settled values only
  always @(negedge i_clk) begin
    if (irq_n === 1'b0) begin
      saw_low = 1'b1;
    end
  end
  fault_flag_and_irq_mask_bank #(.IRQ_PULSE_CYCLES(PULSE)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_divider_mode(i_divider_mode),
    .i_first_group_flag_new(i_first_group_flag_new),
    .i_battery_overvolt(det[0]), .i_battery_overcurrent(det[1]),
    .i_volt_regulation(det[2]), .i_current_regulation(det[3]),
    .i_die_overtemp(det[4]), .i_ratio_below_low(det[5]),
    .i_ratio_below_twice_low(det[6]), .i_ratio_above_high(det[7]),
    .i_ratio_above_twice_high(det[8]), .i_charge_switch_fet_ocp(det[9]),
    .i_discharge_switch_fet_ocp(det[10]),
    .o_fault_irq_mask_first(mask_out), .o_irq_out_low(irq_n));
  host_model H (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  // register model: mask bytes as the host last wrote them, zero on reset
  int mask_model [2] = '{0, 0};
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    H.access(w, a, d, q);
    if (w && a == 8'h0C) begin
      mask_model[0] = d;
    end
    if (w && a == 8'h0E) begin
      mask_model[1] = d;
    end
    if (!w && a == 8'h0C) begin
      `CHK(q, 8'(mask_model[0]))
    end
    if (!w && a == 8'h0E) begin
      `CHK(q, 8'(mask_model[1]))
    end
  endtask : rw
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // watchdog, far beyond the some 840 cycles the run needs
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hd695_b5f8));
    tick(6);
    i_reset <= 1'b0;
    // reset values, 0x0F is unmapped here
    for (int a = 12; a < 16; a++) begin
      rw(1'b0, 8'(a), 8'h00);
      `CHK(q, 8'h00)
    end
    // random masks read back; the flag register ignores writes
    repeat (4) begin
      m1 = $urandom;
      m2 = $urandom;
      rw(1'b1, 8'h0C, m1[7:0]);
      rw(1'b1, 8'h0E, m2[7:0]);
      rw(1'b1, 8'h0D, 8'hFF);
      rw(1'b0, 8'h0C, 8'h00);
      `CHK(q, m1[7:0])
      `CHK(mask_out, m1[7:0])
      rw(1'b0, 8'h0E, 8'h00);
      `CHK(q, m2[7:0])
      rw(1'b0, 8'h0D, 8'h00);
      `CHK(q, 8'h00)
    end
    // first group: each source masked alone, then unmasked alone
    for (int k = 0; k < 16; k++) begin
      m1 = (k < 8) ? (1 << k) : (8'hFF ^ (1 << (k - 8)));
      rw(1'b1, 8'h0C, m1[7:0]);
      saw_low = 1'b0;
      @(posedge i_clk) i_first_group_flag_new <= 8'(1 << (k % 8));
      @(posedge i_clk) i_first_group_flag_new <= 8'h00;
      tick(PULSE + 4);
      `CHK(saw_low, !m1[k % 8])
    end
    // second group in divider mode; level flags persist until gone
    for (int k = 0; k < 16; k++) begin
      b = k % 8;
      m2 = (k < 8) ? (1 << b) : (8'hFF ^ (1 << b));
      rw(1'b1, 8'h0E, m2[7:0]);
      saw_low = 1'b0;
      if (b == 0) begin
        @(posedge i_clk) det[9] <= 1'b1;
        tick(8);
      end
      @(posedge i_clk) det[src[b]] <= 1'b1;
      tick(10);
      `CHK(saw_low, !m2[b])
      rw(1'b0, 8'h0D, 8'h00);
      `CHK(q, 8'(1 << b))
      rw(1'b0, 8'h0D, 8'h00);
      `CHK(q, 8'(lvl[b]) << b)
      @(posedge i_clk) det <= 11'h000;
      tick(10);
      rw(1'b0, 8'h0D, 8'h00);
      `CHK(q, 8'(lvl[b]) << b)
      rw(1'b0, 8'h0D, 8'h00);
      `CHK(q, 8'h00)
    end
    // divider ignores the plain ratio limits and a lone discharge trip
    @(posedge i_clk) det <= 11'h4A0;
    tick(10);
    rw(1'b0, 8'h0D, 8'h00);
    `CHK(q, 8'h00)
    // let the filtered levels fall before the mode flips
    @(posedge i_clk) det <= 11'h000;
    tick(8);
    // bypass uses the plain ratio limits and drops converter trips
    @(posedge i_clk) i_divider_mode <= 1'b0;
    det <= 11'h340;
    tick(10);
    rw(1'b0, 8'h0D, 8'h00);
    `CHK(q, 8'h00)
    @(posedge i_clk) det <= 11'h6A0;
    tick(10);
    rw(1'b0, 8'h0D, 8'h00);
    `CHK(q, 8'h06)
    // reset in mid-run returns both masks to zero
    @(posedge i_clk) i_reset <= 1'b1;
    det <= 11'h000;
    mask_model = '{0, 0};
    tick(2);
    i_reset <= 1'b0;
    rw(1'b0, 8'h0E, 8'h00);
    `CHK(q, 8'h00)
    `CHK(mask_out, 8'h00)
    tally_and_finish();
  end
endmodule : test_fault_flag_and_irq_mask_bank
